// ==== include/phy_mode_pkg.sv ====
package phy_mode_pkg;
    // register map, byte addresses on the apb bus
    localparam logic [11:0] vendor_mode_control_addr    = 12'h010;
    localparam logic [15:0] vendor_mode_control_reset   = 16'h0140;
    // field positions
    localparam int          auto_polarity_disable_bit   = 5;
    localparam int          receive_polarity_invert_bit = 4;
    localparam int          coding_sublayer_bypass_bit  = 1;
    localparam int          receive_clock_gating_bit    = 0;
    // bits software may change, all others hold their reset value
    localparam logic [15:0] vendor_mode_writable_mask   = 16'h0033;
endpackage

// ==== verilog/phy_vendor_mode_control.sv ====
`timescale 1ns/1ps
// How it works
// - register at 0x10, resets to 0x0140
// - bit 5 set turns off auto-polarity
// - auto-polarity inverts reversed 10BASE-T receive
// - auto mode: bit 4 shows inversion, read-only
// - manual mode: software writes bit 4 inversion
// - bit 1 bypasses coding and scrambler 100TX
// - bit 0 stops idle receive clock 100TX
// - loopback suspends receive clock gating
module phy_vendor_mode_control
    import phy_mode_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        speed_100tx,
    input  wire logic        polarity_reversed,
    input  wire logic        receive_active,
    input  wire logic        loopback_select,
    output logic             rx_invert,
    output logic             coding_bypass,
    output logic             rx_clock_enable
);
    logic [15:0] mode_reg;
    logic [15:0] mode_next;
    logic        auto_inv_reg;
    logic        auto_inv_next;
    logic        rx_invert_reg;
    logic        bypass_reg;
    logic        rxclk_en_reg;
    logic        rx_invert_next;
    logic        bypass_next;
    logic        rxclk_en_next;
    logic        pol_meta_reg;
    logic        pol_sync_reg;
    logic        wr_hit;
    logic        hit;
    logic        auto_on;
    logic [15:0] write_mask;
    logic [15:0] rd_value;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    assign hit     = (paddr == vendor_mode_control_addr);
    assign wr_hit  = psel && penable && pwrite && hit;
    assign auto_on = !mode_reg[auto_polarity_disable_bit];
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // synchroniser for the polarity detector pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pol_meta_reg <= 1'b0;
            pol_sync_reg <= 1'b0;
        end else begin
            pol_meta_reg <= polarity_reversed;
            pol_sync_reg <= pol_meta_reg;
        end
    end

    // register write and auto-polarity state
    always_comb begin
        mode_next     = mode_reg;
        auto_inv_next = auto_inv_reg;
        write_mask    = vendor_mode_writable_mask;
        // bit 4 only reports the detector in auto mode, so a write there must not land
        if (auto_on) begin
            write_mask[receive_polarity_invert_bit] = 1'b0;
        end
        if (wr_hit) begin
            mode_next = (mode_reg & ~write_mask)
                      | (pwdata[15:0] & write_mask);
        end
        if (auto_on && !speed_100tx) begin
            auto_inv_next = pol_sync_reg;
        end else if (!auto_on) begin
            auto_inv_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg     <= vendor_mode_control_reset;
            auto_inv_reg <= 1'b0;
        end else begin
            mode_reg     <= mode_next;
            auto_inv_reg <= auto_inv_next;
        end
    end

    // read data: bit 4 shows live inversion in auto mode, zero when unmapped
    always_comb begin
        rd_value = 16'h0000;
        if (hit) begin
            rd_value = mode_reg;
            if (auto_on) begin
                rd_value[receive_polarity_invert_bit] = auto_inv_reg;
            end
        end
        prdata_next = prdata_reg;
        // captured at the end of setup so the word stands through the access cycle
        if (psel && !penable) begin
            prdata_next = {16'h0000, rd_value};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // datapath controls
    always_comb begin
        rx_invert_next = auto_on ? auto_inv_reg
                                 : mode_reg[receive_polarity_invert_bit];
        bypass_next    = mode_reg[coding_sublayer_bypass_bit] && speed_100tx;
        rxclk_en_next  = !(mode_reg[receive_clock_gating_bit] && speed_100tx
                           && !receive_active && !loopback_select);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_invert_reg <= 1'b0;
            bypass_reg    <= 1'b0;
            rxclk_en_reg  <= 1'b1;
        end else begin
            rx_invert_reg <= rx_invert_next;
            bypass_reg    <= bypass_next;
            rxclk_en_reg  <= rxclk_en_next;
        end
    end

    assign rx_invert       = rx_invert_reg;
    assign coding_bypass   = bypass_reg;
    assign rx_clock_enable = rxclk_en_reg;

    // checks
    property p_reset_value;
        @(posedge pclk) $rose(presetn) |-> mode_reg == vendor_mode_control_reset;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

    property p_fixed_bits;
        @(posedge pclk) disable iff (!presetn)
        (mode_reg & ~vendor_mode_writable_mask) == (vendor_mode_control_reset & ~vendor_mode_writable_mask);
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bit changed");

    property p_auto_polarity_disable_off;
        @(posedge pclk) disable iff (!presetn)
        mode_reg[auto_polarity_disable_bit] |=> !auto_inv_reg;
    endproperty
    a_auto_polarity_disable_off: assert property (p_auto_polarity_disable_off) else $error("auto polarity not off");

    sequence s_auto_seen;
        auto_on && !speed_100tx && pol_sync_reg;
    endsequence

    property p_auto_track;
        @(posedge pclk) disable iff (!presetn)
        s_auto_seen ##1 auto_on |=> rx_invert;
    endproperty
    a_auto_track: assert property (p_auto_track) else $error("no auto inversion");

    sequence s_setup_auto;
        psel && !penable && hit && auto_on;
    endsequence

    property p_read_live;
        @(posedge pclk) disable iff (!presetn)
        s_setup_auto |=> prdata[receive_polarity_invert_bit] == $past(auto_inv_reg);
    endproperty
    a_read_live: assert property (p_read_live) else $error("polarity read wrong");

    property p_manual;
        @(posedge pclk) disable iff (!presetn)
        !auto_on |=> rx_invert == $past(mode_reg[receive_polarity_invert_bit]);
    endproperty
    a_manual: assert property (p_manual) else $error("manual polarity wrong");

    property p_bypass;
        @(posedge pclk) disable iff (!presetn)
        (mode_reg[coding_sublayer_bypass_bit] && speed_100tx) |=> coding_bypass;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass missing");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        (mode_reg[receive_clock_gating_bit] && speed_100tx && !receive_active && !loopback_select)
            |=> !rx_clock_enable;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");

    property p_loop;
        @(posedge pclk) disable iff (!presetn)
        loopback_select |=> rx_clock_enable;
    endproperty
    a_loop: assert property (p_loop) else $error("gated in loopback");

    property p_bit4_locked;
        @(posedge pclk) disable iff (!presetn)
        (wr_hit && auto_on)
            |=> mode_reg[receive_polarity_invert_bit] == $past(mode_reg[receive_polarity_invert_bit]);
    endproperty
    a_bit4_locked: assert property (p_bit4_locked) else $error("read-only polarity bit written");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && !hit) |=> $stable(mode_reg);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write changed register");

    property p_bypass_off;
        @(posedge pclk) disable iff (!presetn)
        (!mode_reg[coding_sublayer_bypass_bit] || !speed_100tx) |=> !coding_bypass;
    endproperty
    a_bypass_off: assert property (p_bypass_off) else $error("bypass without request");

    property p_ungated;
        @(posedge pclk) disable iff (!presetn)
        (!mode_reg[receive_clock_gating_bit] || receive_active) |=> rx_clock_enable;
    endproperty
    a_ungated: assert property (p_ungated) else $error("clock stopped while needed");
endmodule

// ==== dv/phy_vendor_mode_control_tb.sv ====
`timescale 1ns/1ps
module phy_vendor_mode_control_tb;
    import phy_mode_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    logic        speed_100tx, polarity_reversed, receive_active, loopback_select;
    logic        rx_invert, coding_bypass, rx_clock_enable;
    int          num_errors, samples_checked;
    phy_vendor_mode_control phy_vendor_mode_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .speed_100tx(speed_100tx),
        .polarity_reversed(polarity_reversed), .receive_active(receive_active),
        .loopback_select(loopback_select), .rx_invert(rx_invert), .coding_bypass(coding_bypass),
        .rx_clock_enable(rx_clock_enable));
    // clock, 40 ns period
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    // one apb transfer, waits for pready; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    // let registered outputs settle after a change
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic t_reset;
        apb(0, vendor_mode_control_addr, 16'h0000);
        chk("reset", 32'h0000_0140, rd);
        chk("okay", 1'b0, err);
        chk("out", 3'b001, {rx_invert, coding_bypass, rx_clock_enable});
        $display("done reset");
    endtask
    task automatic t_manual;
        speed_100tx <= 1;
        apb(1, vendor_mode_control_addr, 16'hfff1);
        apb(0, vendor_mode_control_addr, 16'h0000);
        chk("rdback", 32'h0000_0161, rd);
        apb(1, vendor_mode_control_addr, 16'hfff1);
        apb(0, vendor_mode_control_addr, 16'h0000);
        chk("manual", 32'h0000_0171, rd);
        idle(3);
        chk("force", 3'b100, {rx_invert, coding_bypass, rx_clock_enable});
        loopback_select <= 1;
        idle(3);
        chk("loop", 1'b1, rx_clock_enable);
        loopback_select <= 0;
        receive_active <= 1;
        idle(3);
        chk("rxon", 1'b1, rx_clock_enable);
        receive_active <= 0;
        apb(1, vendor_mode_control_addr, 16'h0022);
        idle(3);
        chk("bypass", 3'b011, {rx_invert, coding_bypass, rx_clock_enable});
        apb(1, vendor_mode_control_addr, 16'h0000);
        idle(3);
        chk("clear", 3'b001, {rx_invert, coding_bypass, rx_clock_enable});
        $display("done manual");
    endtask
    task automatic t_auto;
        speed_100tx <= 0;
        polarity_reversed <= 1;
        idle(6);
        apb(0, vendor_mode_control_addr, 16'h0000);
        chk("auto", 32'h0000_0150, rd);
        chk("inv", 1'b1, rx_invert);
        apb(1, vendor_mode_control_addr, 16'h0020);
        idle(3);
        chk("off", 1'b0, rx_invert);
        apb(1, 12'h014, 16'h0001);
        chk("wrerr", 1'b1, err);
        apb(0, 12'h014, 16'h0000);
        chk("unmap", 32'h0, rd);
        chk("rderr", 1'b1, err);
        apb(0, vendor_mode_control_addr, 16'h0000);
        chk("kept", 32'h0000_0160, rd);
        $display("done auto");
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    initial begin
        num_errors = 0; samples_checked = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; speed_100tx = 0; polarity_reversed = 0;
        receive_active = 0; loopback_select = 0;
        idle(6);
        presetn <= 1;
        t_reset();
        t_manual();
        t_auto();
        test_done();
    end
endmodule
